// *** hdl/l21cmd_pkg.sv ***
`default_nettype none
package l21cmd_pkg;
  localparam logic [7:0] L21_RST_B0   = 8'hFB;
  localparam logic [7:0] L21_RST_B1   = 8'hFC;
  localparam logic [7:0] L21_RST_B2   = 8'h00;
  localparam logic [7:0] L21_NOP      = 8'h00;
  localparam logic [7:0] L21_SYNC_FF  = 8'hFF;
  localparam logic [7:0] L21_SYNC_FE  = 8'hFE;
  localparam logic [7:0] L21_FETCH1   = 8'hF8;
  localparam logic [7:0] L21_FETCH2   = 8'hF9;
  localparam logic [3:0] L21_CHSEL_HI = 4'h1;
  localparam logic [7:0] L21_TEMPLATE_DISPLAY_CMD_LO  = 8'h20;
  localparam logic [7:0] L21_TEMPLATE_DISPLAY_CMD_HI  = 8'h28;
  localparam logic [4:0] L21_STG1_HI  = 5'h08;
  localparam logic [4:0] L21_STG2_HI  = 5'h0C;
  localparam logic [2:0] L21_STG2_MAX = 3'h6;
  localparam logic [2:0] L21_WR_HI    = 3'h6;
  localparam logic [7:0] L21_OSD_RET  = 8'h30;
  localparam logic [7:0] L21_OSD_CLEAR_TO_ROW_END_CMD = 8'h31;
  localparam logic [7:0] L21_OSD_TEXT = 8'h32;
  localparam logic [7:0] L21_OSD_POP  = 8'h33;
  localparam logic [7:0] L21_OSD_FLIP = 8'h36;
  localparam logic [7:0] L21_OSD_EDM  = 8'h37;
  localparam logic [7:0] L21_OSD_ENM  = 8'h38;
  localparam int         L21_NREG     = 32;
  localparam logic [7:0] L21_REG_RST  = 8'h00;
  localparam int         L21_SYNC_MIN = 2;
  localparam int         L21_ST_RDY   = 7;
  localparam int         L21_ST_DAV   = 6;
  localparam int         L21_ST_RD2   = 5;
endpackage : l21cmd_pkg
`default_nettype wire

// *** hdl/l21cmd_if.sv ***
`default_nettype none
interface l21cmd_if;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       spi_mode;
  logic       rsp_valid;
  logic [7:0] rsp_byte;
  logic [7:0] status;
  modport dev  (input cmd_valid, cmd_byte, spi_mode, output rsp_valid, rsp_byte, status);
  modport host (output cmd_valid, cmd_byte, spi_mode, input rsp_valid, rsp_byte, status);
endinterface : l21cmd_if
`default_nettype wire

// *** hdl/l21cmd_dev.sv ***
// Functional notes
// - reset sequence restores defaults, keeps port state
// - no-op accepted anytime, ready unchanged in spi mode (outside spi any byte sets ready)
// - spi sync: two ff then fe
// - channel select picks caption/text channel
// - template select, erase timer choice
// - one-byte stage copies addressed register
// - two-byte stage copies pair, sets flag
// - spi fetch-one returns staged byte
// - spi fetch-two returns both bytes
// - write opcode plus data byte stores
// - return only in text-style mode
// - clear cursor to row end
// - text setup enters text-style mode
// - pop-on setup enters pop-on mode
// - flip swaps shown and hidden memory
// - erase shown memory
// - erase hidden memory
// - data-available and two-byte flags together
`default_nettype none
module l21cmd_dev
  import l21cmd_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  l21cmd_if.dev           bus,
  output logic [2:0]      o_channel,
  output logic [3:0]      o_template,
  output logic            o_erase_timer_en,
  output logic            o_text_mode,
  output logic            o_popon_mode,
  output logic            o_shown_bank,
  output logic            o_osd_return,
  output logic            o_clear_row_end,
  output logic            o_erase_shown,
  output logic            o_erase_hidden
);
  import l21cmd_pkg::*;
  logic [7:0] regs_reg [L21_NREG];
  logic [7:0] out0_reg, out1_reg;
  logic       dav_reg, rd2_reg, rdy_reg, half_reg;
  logic       wr_pend_reg;
  logic [4:0] wr_addr_reg;
  logic [1:0] rst_seq_reg;
  logic [1:0] sync_cnt_reg;
  logic       fetch2_reg;
  logic       rsp_valid_reg;
  logic [7:0] rsp_byte_reg;
  logic       defaults;
  logic [7:0] b;
  assign b = bus.cmd_byte;
  // reset sequence tracker; port sync state is separate so it survives
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_seq_reg <= 2'd0;
    end else if (bus.cmd_valid) begin
      if (b == L21_RST_B0) begin
        rst_seq_reg <= 2'd1;
      end else if (rst_seq_reg == 2'd1 && b == L21_RST_B1) begin
        rst_seq_reg <= 2'd2;
      end else begin
        rst_seq_reg <= 2'd0;
      end
    end
  end
  assign defaults = bus.cmd_valid && rst_seq_reg == 2'd2 && b == L21_RST_B2;
  // spi sync: port unusable until ff,ff,...,fe seen
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_cnt_reg <= 2'd0;
      rdy_reg      <= 1'b0;
    end else if (bus.cmd_valid && bus.spi_mode) begin
      if (b == L21_SYNC_FF) begin
        sync_cnt_reg <= (sync_cnt_reg == 2'd3) ? 2'd3 : sync_cnt_reg + 2'd1;
      end else begin
        if (b == L21_SYNC_FE && sync_cnt_reg >= 2'(L21_SYNC_MIN)) begin
          rdy_reg <= 1'b1;
        end
        sync_cnt_reg <= 2'd0;
      end
    end else if (bus.cmd_valid && !bus.spi_mode) begin
      rdy_reg <= 1'b1;
    end
  end
  // command decode; ready gates everything but no-op and reset bytes
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < L21_NREG; i++) regs_reg[i] <= L21_REG_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 5'd0;
      out0_reg    <= 8'h00_00;
      out1_reg    <= 8'h00_00;
      dav_reg     <= 1'b0;
      rd2_reg     <= 1'b0;
      half_reg    <= 1'b0;
      fetch2_reg  <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_byte_reg  <= 8'h00_00;
      o_channel   <= 3'd0;
      o_template  <= 4'd0;
      o_erase_timer_en <= 1'b0;
      o_text_mode <= 1'b0;
      o_popon_mode <= 1'b0;
      o_shown_bank <= 1'b0;
      o_osd_return <= 1'b0;
      o_clear_row_end <= 1'b0;
      o_erase_shown <= 1'b0;
      o_erase_hidden <= 1'b0;
    end else begin
      rsp_valid_reg   <= 1'b0;
      o_osd_return    <= 1'b0;
      o_clear_row_end <= 1'b0;
      o_erase_shown   <= 1'b0;
      o_erase_hidden  <= 1'b0;
      if (defaults) begin
        for (int i = 0; i < L21_NREG; i++) regs_reg[i] <= L21_REG_RST;
        wr_pend_reg <= 1'b0;
        dav_reg <= 1'b0;
        rd2_reg <= 1'b0;
        o_channel <= 3'd0;
        o_template <= 4'd0;
        o_erase_timer_en <= 1'b0;
        o_text_mode <= 1'b0;
        o_popon_mode <= 1'b0;
        o_shown_bank <= 1'b0;
      end else if (bus.cmd_valid && wr_pend_reg) begin
        regs_reg[wr_addr_reg] <= b;
        wr_pend_reg <= 1'b0;
      end else if (bus.cmd_valid && b != L21_NOP && rdy_reg) begin
        if (b[7:4] == L21_CHSEL_HI) begin
          o_channel <= b[2:0];
        end else if (b >= L21_TEMPLATE_DISPLAY_CMD_LO && b <= L21_TEMPLATE_DISPLAY_CMD_HI) begin
          o_template <= b[3:0];
          o_erase_timer_en <= b[0];
        end else if (b[7:3] == L21_STG1_HI) begin
          out0_reg <= regs_reg[{2'b00, b[2:0]}];
          dav_reg <= 1'b1;
          rd2_reg <= 1'b0;
          half_reg <= 1'b0;
        end else if (b[7:3] == L21_STG2_HI && b[2:0] <= L21_STG2_MAX) begin
          out0_reg <= regs_reg[{2'b00, b[2:0]}];
          out1_reg <= regs_reg[{2'b00, b[2:0]} + 5'd1];
          dav_reg <= 1'b1;
          rd2_reg <= 1'b1;
          half_reg <= 1'b0;
        end else if (b[7:5] == L21_WR_HI) begin
          wr_addr_reg <= b[4:0];
          wr_pend_reg <= 1'b1;
        end else if (bus.spi_mode && b == L21_FETCH1) begin
          rsp_valid_reg <= 1'b1;
          rsp_byte_reg <= half_reg ? out1_reg : out0_reg;
          dav_reg <= 1'b0;
          rd2_reg <= 1'b0;
        end else if (bus.spi_mode && b == L21_FETCH2) begin
          rsp_valid_reg <= 1'b1;
          rsp_byte_reg <= out0_reg;
          fetch2_reg <= 1'b1;
        end else begin
          case (b)
            L21_OSD_RET:  o_osd_return <= o_text_mode;
            L21_OSD_CLEAR_TO_ROW_END_CMD: o_clear_row_end <= 1'b1;
            L21_OSD_TEXT: begin
              o_text_mode <= 1'b1;
              o_popon_mode <= 1'b0;
            end
            L21_OSD_POP: begin
              o_popon_mode <= 1'b1;
              o_text_mode <= 1'b0;
            end
            L21_OSD_FLIP: o_shown_bank <= ~o_shown_bank;
            L21_OSD_EDM:  o_erase_shown <= 1'b1;
            L21_OSD_ENM:  o_erase_hidden <= 1'b1;
            default: ;
          endcase
        end
      end
      // second byte of a two-byte fetch follows one cycle later
      if (fetch2_reg) begin
        fetch2_reg <= 1'b0;
        rsp_valid_reg <= 1'b1;
        rsp_byte_reg <= out1_reg;
        dav_reg <= 1'b0;
        rd2_reg <= 1'b0;
      end
    end
  end
  assign bus.rsp_valid = rsp_valid_reg;
  assign bus.rsp_byte  = rsp_byte_reg;
  assign bus.status    = {rdy_reg, dav_reg, rd2_reg, 5'b0_0000};
endmodule : l21cmd_dev
`default_nettype wire

// *** hdl/l21cmd_host.sv ***
`default_nettype none
module l21cmd_host
  import l21cmd_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  l21cmd_if.host          bus,
  input  wire logic       i_spi_mode,
  input  wire logic       i_req,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_force,
  output logic            o_taken,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_byte,
  output logic            o_ready
);
  import l21cmd_pkg::*;
  logic       go;
  logic       cmd_valid_reg;
  logic [7:0] cmd_byte_reg;
  // non-ready commands held back unless reset/no-op bytes (forced)
  assign go = i_req && (i_force || i_byte == L21_NOP || bus.status[L21_ST_RDY]);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_valid_reg <= 1'b0;
      cmd_byte_reg  <= 8'h00_00;
      o_taken       <= 1'b0;
      o_rsp_valid   <= 1'b0;
      o_rsp_byte    <= 8'h00_00;
      o_ready       <= 1'b0;
    end else begin
      cmd_valid_reg <= go;
      cmd_byte_reg  <= i_byte;
      o_taken       <= go;
      o_rsp_valid   <= bus.rsp_valid;
      o_rsp_byte    <= bus.rsp_byte;
      o_ready       <= bus.status[L21_ST_RDY];
    end
  end
  assign bus.cmd_valid = cmd_valid_reg;
  assign bus.cmd_byte  = cmd_byte_reg;
  assign bus.spi_mode  = i_spi_mode;
endmodule : l21cmd_host
`default_nettype wire

// *** sim/l21cmd_asserts.sv ***
`default_nettype none
module l21cmd_asserts
  import l21cmd_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst_b,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       spi_mode,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic [7:0] status
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic rdy;
  logic f1;
  logic f2;
  assign rdy = status[L21_ST_RDY];
  // refused fetches (not ready) are left out on purpose
  assign f1  = cmd_valid && cmd_byte == L21_FETCH1 && spi_mode && rdy;
  assign f2  = cmd_valid && cmd_byte == L21_FETCH2 && spi_mode && rdy;
  sequence two_out;
    rsp_valid ##1 rsp_valid;
  endsequence
  a_fetch_one: assert property (f1 |=> rsp_valid)
    else $error("fetch one gave no byte");
  a_fetch_two: assert property (f2 |=> two_out)
    else $error("fetch two gave no pair");
  a_i2c_fetch_off: assert property (cmd_valid && !spi_mode && cmd_byte == L21_FETCH1
    |=> !rsp_valid) else $error("fetch answered outside spi");
  a_rsp_has_cause: assert property (rsp_valid |-> $past(f1) || $past(f2) || $past(f2, 2))
    else $error("byte sent with no fetch");
  a_sync_ready: assert property ($rose(rdy) && spi_mode |-> $past(cmd_valid)
    && $past(cmd_byte) == L21_SYNC_FE) else $error("ready without sync end");
  a_nop_keeps: assert property (cmd_valid && spi_mode && cmd_byte == L21_NOP
    |=> rdy == $past(rdy)) else $error("no-op changed ready");
  a_pair_flags: assert property (status[L21_ST_RD2] |-> status[L21_ST_DAV])
    else $error("two-byte flag without data flag");
  a_stage_two: assert property (cmd_valid && rdy && cmd_byte inside {[8'h60:8'h66]}
    |=> status[L21_ST_RD2] && status[L21_ST_DAV]) else $error("stage two no flags");
  a_stage_bad: assert property (cmd_valid && rdy && cmd_byte == 8'h67 && !status[L21_ST_RD2]
    |=> !status[L21_ST_RD2]) else $error("bad stage two accepted");
endmodule : l21cmd_asserts
`default_nettype wire

// *** sim/l21cmd_tb_top.sv ***
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module l21cmd_tb_top
  import l21cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_rst_b, spi, req, frc, taken, rv, rdy;
  logic etim, txt, pop, bank, ret, clr, esh, ehd;
  logic [7:0] byt, rb;
  logic [2:0] chan;
  logic [3:0] tmpl;
  int fail_count, tests_run;
  int pc[4];
  logic [7:0] rq[$];
  l21cmd_if bus();
  l21cmd_host u_l21cmd_host(.i_sys_clk, .i_rst_b, .bus(bus), .i_spi_mode(spi), .i_req(req),
    .i_byte(byt), .i_force(frc), .o_taken(taken), .o_rsp_valid(rv), .o_rsp_byte(rb),
    .o_ready(rdy));
  l21cmd_dev u_l21cmd_dev(.i_sys_clk, .i_rst_b, .bus(bus), .o_channel(chan),
    .o_template(tmpl), .o_erase_timer_en(etim), .o_text_mode(txt), .o_popon_mode(pop),
    .o_shown_bank(bank), .o_osd_return(ret), .o_clear_row_end(clr), .o_erase_shown(esh),
    .o_erase_hidden(ehd));
  l21cmd_asserts u_l21cmd_asserts(.i_sys_clk, .i_rst_b, .cmd_valid(bus.cmd_valid),
    .cmd_byte(bus.cmd_byte), .spi_mode(bus.spi_mode), .rsp_valid(bus.rsp_valid),
    .rsp_byte(bus.rsp_byte), .status(bus.status));
  initial begin
    i_sys_clk = 0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // counting pulses keeps checks free of exact pulse timing
  always @(posedge i_sys_clk) begin
    if (rv === 1'b1) rq.push_back(rb);
    pc[0] += int'(ret === 1'b1);
    pc[1] += int'(clr === 1'b1);
    pc[2] += int'(esh === 1'b1);
    pc[3] += int'(ehd === 1'b1);
  end
  task results;
    $display("mismatches %0d checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // an unready host may hold a byte back, so a missing take only counts when due
  task send(input logic [7:0] b, input logic f);
    int n;
    n = 0;
    @(posedge i_sys_clk); #1;
    req = 1;
    byt = b;
    frc = f;
    @(posedge i_sys_clk); #1;
    req = 0;
    while (taken !== 1'b1 && n < 8) begin
      @(posedge i_sys_clk); #1;
      n++;
    end
    if (n == 8 && (f || rdy === 1'b1)) begin
      fail_count++;
      results();
    end
    // two-byte answer reaches the host outputs three edges after the take
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask : send
  task wr(input logic [4:0] a, input logic [7:0] d);
    send({3'b110, a}, 0);
    send(d, 0);
  endtask : wr
  task fetch(input logic [7:0] stg, input logic two, input logic [15:0] e);
    rq.delete();
    send(stg, 0);
    if (two) `CHK("flags", 2'b11, {bus.status[L21_ST_DAV], bus.status[L21_ST_RD2]})
    send(two ? L21_FETCH2 : L21_FETCH1, 0);
    `CHK("count", two ? 1 + 1 : 1, rq.size())
    `CHK("byte0", two ? e[15:8] : e[7:0], rq[0])
    if (two) `CHK("byte1", e[7:0], rq[1])
    if (two) `CHK("flags clr", 2'b00, {bus.status[L21_ST_DAV], bus.status[L21_ST_RD2]})
  endtask : fetch
  initial begin
    i_rst_b = 0;
    spi = 1;
    req = 0;
    frc = 0;
    byt = 8'h00;
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1;
    send(L21_NOP, 1);
    `CHK("nop unready", 1'b0, rdy)
    send(L21_OSD_POP, 1);
    `CHK("refused", 1'b0, pop)
    send(L21_SYNC_FF, 1);
    send(L21_SYNC_FF, 1);
    send(L21_SYNC_FE, 1);
    `CHK("sync", 1'b1, rdy)
    send(L21_NOP, 0);
    `CHK("nop ready", 1'b1, rdy)
    wr(5'h05, 8'h41);
    wr(5'h06, 8'hA7);
    wr(5'h07, 8'h3C);
    wr(5'h00, 8'h5A);
    fetch(8'h45, 0, 16'h0041);
    fetch(8'h47, 0, 16'h003C);
    fetch(8'h40, 0, 16'h005A);
    fetch(8'h65, 1, 16'h41A7);
    fetch(8'h66, 1, 16'hA73C);
    send(8'h67, 0);
    `CHK("stage 7", 1'b0, bus.status[L21_ST_RD2])
    spi = 0;
    rq.delete();
    send(L21_FETCH1, 0);
    `CHK("i2c fetch", 0, rq.size())
    spi = 1;
    for (int i = 0; i < 16; i++) begin
      send(8'(8'h10 + i), 0);
      `CHK("channel", i[2:0], chan)
    end
    for (int i = 0; i < 9; i++) begin
      send(8'(8'h20 + i), 0);
      `CHK("template", i[3:0], tmpl)
      `CHK("timer", i[0], etim)
    end
    send(L21_OSD_TEXT, 0);
    `CHK("text", 1'b1, txt)
    send(L21_OSD_RET, 0);
    `CHK("return", 1, pc[0])
    send(L21_OSD_POP, 0);
    `CHK("popon", 2'b10, {pop, txt})
    send(L21_OSD_RET, 0);
    `CHK("no return", 1, pc[0])
    send(L21_OSD_CLEAR_TO_ROW_END_CMD, 0);
    `CHK("clear", 1, pc[1])
    send(L21_OSD_FLIP, 0);
    `CHK("flip", 1'b1, bank)
    send(L21_OSD_EDM, 0);
    `CHK("erase shown", 1, pc[2])
    send(L21_OSD_ENM, 0);
    `CHK("erase hidden", 1, pc[3])
    send(L21_RST_B0, 1);
    send(L21_RST_B1, 1);
    send(L21_RST_B2, 1);
    `CHK("reset keeps", 2'b10, {rdy, pop})
    fetch(8'h45, 0, 16'h0000);
    results();
  end
endmodule : l21cmd_tb_top
`default_nettype wire
